// >>> verif/dera_access_bench.sv
/* Self-checking bench for dera_access with a far-side model.
   Assumes a short programming time set through PROG_CYCLES. */
`timescale 1ns/10ps
`default_nettype none
module dera_access_bench;
    localparam int PROG = 20;
    logic ref_clk = 1'b0, arst_n = 1'b0, supply_ok = 1'b1;
    logic int_req = 1'b0, int_we = 1'b0, int_indirect = 1'b0;
    logic int_stack = 1'b0, xd_req = 1'b0, xd_we = 1'b0;
    logic [7:0] int_addr = 8'h00, int_wdata = 8'h00, xd_wdata = 8'h00;
    logic [15:0] xd_addr = 16'h0000, a, ext_addr_q;
    logic [7:0] int_rdata_q, sfr_addr_q, sfr_wdata_q, sfr_rdata, d, a8;
    logic [7:0] xd_rdata_q, ext_wdata_q, ext_rdata, pd [4];
    logic sfr_req_q, sfr_we_q, ext_req_q, ext_we_q, pointer_select_q;
    int n_mismatch = 0, cmp_count = 0, i;
    integer seed = 32'hCDE9;
    always #50 ref_clk = ~ref_clk;
    dera_access #(.PROG_CYCLES(PROG)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .int_req(int_req),
        .int_we(int_we), .int_indirect(int_indirect),
        .int_stack(int_stack), .int_addr(int_addr),
        .int_wdata(int_wdata), .int_rdata_q(int_rdata_q),
        .sfr_req_q(sfr_req_q), .sfr_we_q(sfr_we_q),
        .sfr_addr_q(sfr_addr_q), .sfr_wdata_q(sfr_wdata_q),
        .sfr_rdata(sfr_rdata), .xd_req(xd_req), .xd_we(xd_we),
        .xd_addr(xd_addr), .xd_wdata(xd_wdata), .xd_rdata_q(xd_rdata_q),
        .ext_req_q(ext_req_q), .ext_we_q(ext_we_q),
        .ext_addr_q(ext_addr_q), .ext_wdata_q(ext_wdata_q),
        .ext_rdata(ext_rdata), .supply_ok(supply_ok),
        .pointer_select_q(pointer_select_q));
    dera_far_model u_far (
        .ref_clk(ref_clk), .sfr_req_q(sfr_req_q),
        .sfr_addr_q(sfr_addr_q), .sfr_rdata(sfr_rdata),
        .ext_req_q(ext_req_q), .ext_addr_q(ext_addr_q),
        .ext_rdata(ext_rdata));
    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] f_ext(input logic [15:0] ad);
        return ad[7:0] ^ ad[15:8] ^ 8'hC3;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Three cycles cover both the one- and two-cycle answers
    task automatic iacc(input logic we, ind, stk, input logic [7:0] ad, wd);
        int_req = 1'b1;
        int_we = we;
        int_indirect = ind;
        int_stack = stk;
        int_addr = ad;
        int_wdata = wd;
        @(negedge ref_clk);
        int_req = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic xacc(input logic we, input logic [15:0] ad,
                        input logic [7:0] wd);
        xd_req = 1'b1;
        xd_we = we;
        xd_addr = ad;
        xd_wdata = wd;
        @(negedge ref_clk);
        xd_req = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic ctl(input logic [7:0] v);
        iacc(1'b1, 1'b0, 1'b0, 8'h96, v);
    endtask
    task automatic rctl(input logic [7:0] exp);
        iacc(1'b0, 1'b0, 1'b0, 8'h96, 8'h00);
        chk(int_rdata_q, exp);
    endtask
    // Bounded poll of the ready bit, which rises only after the commit, then 40 idle cycles
    task automatic wait_rdy;
        iacc(1'b0, 1'b0, 1'b0, 8'h96, 8'h00);
        for (int k = 0; k < 2 * PROG && !int_rdata_q[1]; k++)
            iacc(1'b0, 1'b0, 1'b0, 8'h96, 8'h00);
        chk({7'h00, int_rdata_q[1]}, 8'h01);
        repeat (40) @(negedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge ref_clk);
        arst_n = 1'b1;
        @(negedge ref_clk);
        rctl(8'h03);
        ctl(8'hFF);
        rctl(8'h3F);
        chk({7'h00, pointer_select_q}, 8'h01);
        ctl(8'h00);
        chk({7'h00, pointer_select_q}, 8'h00);
        // Upper RAM against registers at the same address
        for (i = 0; i < 40; i++) begin
            a8 = 8'h80 | 8'($random(seed));
            a8 = (a8 == 8'h96) ? 8'h97 : a8;
            d = 8'($random(seed));
            iacc(1'b1, !i[0], i[0], a8, d);
            iacc(1'b1, 1'b0, 1'b0, a8, ~d);
            chk(sfr_wdata_q, ~d);
            iacc(1'b0, 1'b0, 1'b0, a8, 8'h00);
            chk(int_rdata_q, a8 ^ 8'h5A);
            iacc(1'b0, i[0], !i[0], a8, 8'h00);
            chk(int_rdata_q, d);
        end
        for (i = 0; i < 8; i++) begin
            a = 16'($random(seed));
            xacc(1'b0, a, 8'h00);
            chk(xd_rdata_q, f_ext(a));
        end
        xacc(1'b1, a, d);
        chk(ext_wdata_q, d);
        ctl(8'h08);
        xacc(1'b0, 16'h0800, 8'h00);
        chk(xd_rdata_q, f_ext(16'h0800));
        // Byte writes: the neighbour must survive
        ctl(8'h18);
        a = 16'h0123;
        xacc(1'b1, a + 16'h0001, 8'hA5);
        wait_rdy();
        xacc(1'b1, a, 8'h3C);
        rctl(8'h19);
        xacc(1'b0, a, 8'h00);
        chk(xd_rdata_q, 8'hBC);
        wait_rdy();
        xacc(1'b0, a, 8'h00);
        chk(xd_rdata_q, 8'h3C);
        xacc(1'b0, a + 16'h0001, 8'h00);
        chk(xd_rdata_q, 8'hA5);
        ctl(8'h08);
        xacc(1'b1, a, 8'h00);
        rctl(8'h0B);
        repeat (40) @(negedge ref_clk);
        xacc(1'b0, a, 8'h00);
        chk(xd_rdata_q, 8'h3C);
        // Page write: three loads, then the final byte starts it
        ctl(8'h38);
        for (i = 0; i < 4; i++) begin
            pd[i] = 8'($random(seed));
            if (i == 3)
                ctl(8'h18);
            xacc(1'b1, 16'h0240 + 16'(i * 10), pd[i]);
            rctl(i == 3 ? 8'h19 : 8'h3B);
        end
        wait_rdy();
        for (i = 0; i < 4; i++) begin
            xacc(1'b0, 16'h0240 + 16'(i * 10), 8'h00);
            chk(xd_rdata_q, pd[i]);
        end
        // Low supply blocks a start and aborts a running cycle
        supply_ok = 1'b0;
        repeat (2) @(negedge ref_clk);
        xacc(1'b1, a, 8'h77);
        rctl(8'h1A);
        supply_ok = 1'b1;
        repeat (2) @(negedge ref_clk);
        xacc(1'b1, a, 8'h66);
        supply_ok = 1'b0;
        repeat (5) @(negedge ref_clk);
        supply_ok = 1'b1;
        repeat (50) @(negedge ref_clk);
        rctl(8'h1B);
        xacc(1'b0, a, 8'h00);
        chk(xd_rdata_q, 8'h3C);
        // Reset while idle restores the register
        arst_n = 1'b0;
        @(negedge ref_clk);
        arst_n = 1'b1;
        @(negedge ref_clk);
        rctl(8'h03);
        give_verdict();
    end
    // Watchdog sized well above the expected run length
    initial begin
        #500000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/dera_access_props.sv
/* Port checker for dera_access: routing, read return and pointer select.
   Assumes one clock, async active-low reset, bound by the bind below. */
`timescale 1ns/10ps
`default_nettype none
module dera_access_props (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        int_req,
    input wire logic        int_we,
    input wire logic        int_indirect,
    input wire logic        int_stack,
    input wire logic [7:0]  int_addr,
    input wire logic [7:0]  int_wdata,
    input wire logic [7:0]  int_rdata_q,
    input wire logic        sfr_req_q,
    input wire logic        sfr_we_q,
    input wire logic [7:0]  sfr_addr_q,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        xd_req,
    input wire logic [15:0] xd_addr,
    input wire logic [7:0]  xd_rdata_q,
    input wire logic        ext_req_q,
    input wire logic        ext_we_q,
    input wire logic [15:0] ext_addr_q,
    input wire logic [7:0]  ext_rdata,
    input wire logic        pointer_select_q
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic memen_q;
    wire  ctl_wr = int_req && int_we && !int_indirect && !int_stack
                   && int_addr == 8'h96;
    // Enable mirror, since the checker sees only the ports
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            memen_q <= 1'b0;
        else if (ctl_wr)
            memen_q <= int_wdata[3];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_dir;
        int_req && !int_indirect && !int_stack && int_addr > 8'h7F
            && int_addr != 8'h96;
    endsequence
    sequence s_sfr_rd;
        s_dir ##1 (sfr_req_q && !sfr_we_q);
    endsequence
    property p_sfr_route;
        s_dir |=> sfr_req_q && sfr_addr_q == $past(int_addr);
    endproperty
    a_sfr_route: assert property (p_sfr_route)
        else $error("direct access not forwarded");
    property p_sfr_read;
        s_sfr_rd |=> int_rdata_q == $past(sfr_rdata);
    endproperty
    a_sfr_read: assert property (p_sfr_read)
        else $error("register read data lost");
    property p_ind_ram;
        int_req && int_indirect |=> !sfr_req_q;
    endproperty
    a_ind_ram: assert property (p_ind_ram)
        else $error("indirect access reached a register");
    property p_stack_ram;
        int_req && int_stack |=> !sfr_req_q;
    endproperty
    a_stack_ram: assert property (p_stack_ram)
        else $error("stack access reached a register");
    property p_ee_route;
        xd_req && memen_q && xd_addr <= 16'h07FF |=> !ext_req_q;
    endproperty
    a_ee_route: assert property (p_ee_route)
        else $error("on-chip move went off chip");
    property p_off_route;
        xd_req && (!memen_q || xd_addr > 16'h07FF)
            |=> ext_req_q && ext_addr_q == $past(xd_addr);
    endproperty
    a_off_route: assert property (p_off_route)
        else $error("off-chip move not issued");
    property p_off_read;
        ext_req_q && !ext_we_q |=> xd_rdata_q == $past(ext_rdata);
    endproperty
    a_off_read: assert property (p_off_read)
        else $error("off-chip read data lost");
    property p_psel_set;
        ctl_wr |=> pointer_select_q == $past(int_wdata[2]);
    endproperty
    a_psel_set: assert property (p_psel_set)
        else $error("pointer select not written");
    property p_psel_hold;
        !ctl_wr |=> $stable(pointer_select_q);
    endproperty
    a_psel_hold: assert property (p_psel_hold)
        else $error("pointer select moved by itself");
endmodule
bind dera_access dera_access_props u_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .int_req(int_req),
    .int_we(int_we), .int_indirect(int_indirect), .int_stack(int_stack),
    .int_addr(int_addr), .int_wdata(int_wdata),
    .int_rdata_q(int_rdata_q), .sfr_req_q(sfr_req_q),
    .sfr_we_q(sfr_we_q), .sfr_addr_q(sfr_addr_q),
    .sfr_rdata(sfr_rdata), .xd_req(xd_req), .xd_addr(xd_addr),
    .xd_rdata_q(xd_rdata_q), .ext_req_q(ext_req_q),
    .ext_we_q(ext_we_q), .ext_addr_q(ext_addr_q),
    .ext_rdata(ext_rdata), .pointer_select_q(pointer_select_q));
`default_nettype wire

// >>> verif/dera_far_model.sv
/* Far-side responders: register file and off-chip data memory.
   Assumes read data is sampled in the cycle the request is high. */
`timescale 1ns/10ps
`default_nettype none
module dera_far_model (
    input  wire logic        ref_clk,
    input  wire logic        sfr_req_q,
    input  wire logic [7:0]  sfr_addr_q,
    output var  logic [7:0]  sfr_rdata,
    input  wire logic        ext_req_q,
    input  wire logic [15:0] ext_addr_q,
    output var  logic [7:0]  ext_rdata
);
    logic [7:0] sfr_last = 8'h00;
    logic [7:0] ext_last = 8'h00;
    // Idle lines show the inverse of the previous cycle's value, so a late
    // sample cannot pass for a good one
    always_comb
        sfr_rdata = sfr_req_q ? (sfr_addr_q ^ 8'h5A) : ~sfr_last;
    always_comb
        ext_rdata = ext_req_q ? (ext_addr_q[7:0] ^ ext_addr_q[15:8]
                    ^ 8'hC3) : ~ext_last;
    always @(posedge ref_clk) begin
        sfr_last <= sfr_rdata;
        ext_last <= ext_rdata;
    end
endmodule
`default_nettype wire

// >>> verilog/dera_access.v
/*
 * Data memory access steering for an 8-bit core: internal RAM versus
 * special function registers, external data moves to the on-chip
 * EEPROM or off chip, byte and page programming, status and pointer
 * select. Assumes the core presents one access per strobe, synchronous
 * to ref_clk, and that read data is sampled one cycle after the strobe, two for special register and off-chip reads.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dera_defs.vh"

// Overview of operation
// - Direct accesses above 7FH reach special registers
// - Indirect accesses above 7FH reach upper RAM
// - Stack pushes and pops count as indirect
// - Enable bit routes external moves to EEPROM
// - Enable clear sends external moves off chip
// - Byte write rewrites only the addressed byte
// - Write cycle is self-timed, about 4 ms
// - Ready bit low while busy, high after
// - Load-only bit just fills the buffer
// - Clear load-only before final page write
// - Page cycle commits buffered same-page bytes
// - Reads of the byte being written return inverted-MSB data while busy
// - Control register bit layout 5 down to 0
// - Control register carries pointer select bit
// - Select 0 first bank, 1 second
// - Addresses 2K and above go off chip
// - Low supply aborts and blocks programming
module dera_access #(
    parameter PROG_CYCLES = `DERA_PROG_CYCLES,
    parameter PAGE_BYTES  = `DERA_PAGE_BYTES,
    parameter PAGE_AW     = `DERA_PAGE_AW,
    parameter EE_AW       = `DERA_EE_AW
) (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        int_req,
    input  wire        int_we,
    input  wire        int_indirect,
    input  wire        int_stack,
    input  wire [7:0]  int_addr,
    input  wire [7:0]  int_wdata,
    output reg  [7:0]  int_rdata_q,
    output reg         sfr_req_q,
    output reg         sfr_we_q,
    output reg  [7:0]  sfr_addr_q,
    output reg  [7:0]  sfr_wdata_q,
    input  wire [7:0]  sfr_rdata,
    input  wire        xd_req,
    input  wire        xd_we,
    input  wire [15:0] xd_addr,
    input  wire [7:0]  xd_wdata,
    output reg  [7:0]  xd_rdata_q,
    output reg         ext_req_q,
    output reg         ext_we_q,
    output reg  [15:0] ext_addr_q,
    output reg  [7:0]  ext_wdata_q,
    input  wire [7:0]  ext_rdata,
    input  wire        supply_ok,
    output reg         pointer_select_q
);

    // ------------------------------------------------------------------
    // Storage and control state
    // ------------------------------------------------------------------
    reg  [7:0]        ram [0:255];
    reg  [7:0]        eeprom [0:(1<<EE_AW)-1];
    reg               load_only_q;
    reg               eeprom_write_enable_q;
    reg               internal_memory_enable_q;
    reg               write_inhibit_flag_q;

    // Running cycle and copy-out walk
    reg  [EE_AW-1:0]  prog_addr_q;
    reg  [7:0]        prog_data_q;
    reg  [PAGE_AW:0]  commit_idx_q;
    reg               committing_q;
    reg               int_rd_sfr_q;

    // Timer state and software-visible busy
    wire              busy;
    wire              done;
    wire              prog_busy;
    wire [7:0]        buf_rdata;
    wire              buf_rvalid;
    wire [7:0]        ctrl_rd;
    wire              to_sfr;
    wire              ctrl_hit;
    wire              ee_hit;
    wire              ee_wr;
    wire              ee_buf_wr;
    wire              ee_start;
    wire [EE_AW-1:0]  ee_addr;
    wire [EE_AW-1:0]  commit_addr;

    // ------------------------------------------------------------------
    // Internal space decode
    // ------------------------------------------------------------------
    // Stack traffic is indirect by nature, so upper RAM can hold it
    assign to_sfr   = (int_addr > `DERA_LOWER_TOP)
                      && !int_indirect && !int_stack;
    // This block answers for the control register
    assign ctrl_hit = to_sfr && (int_addr == `DERA_CTRL_ADDR);

    // Control register image; bits 7:6 read zero
    // Ready stays low through the copy-out too
    assign ctrl_rd = {2'b00, load_only_q, eeprom_write_enable_q,
                      internal_memory_enable_q, pointer_select_q,
                      !prog_busy, write_inhibit_flag_q};

    // ------------------------------------------------------------------
    // External data decode
    // ------------------------------------------------------------------
    // At 2K and up a move always goes off chip
    assign ee_hit  = internal_memory_enable_q
                     && (xd_addr <= `DERA_EE_TOP);
    assign ee_addr = xd_addr[EE_AW-1:0];

    // No load and no programming unless write enable is set
    assign ee_wr     = xd_req && xd_we && ee_hit
                       && eeprom_write_enable_q;
    // A write arriving while busy or inhibited is dropped whole;
    // the core is never stalled, so software polls ready first
    assign ee_buf_wr = ee_wr && !prog_busy && write_inhibit_flag_q;
    assign ee_start  = ee_buf_wr && !load_only_q;

    // Copy-out target: page of the start, slot of the walk
    assign commit_addr = {prog_addr_q[EE_AW-1:PAGE_AW],
                          commit_idx_q[PAGE_AW-1:0]};

    // Busy as software sees it: timer run plus copy-out, so
    // ready rises only once the array holds the new bytes
    assign prog_busy = busy || done || committing_q;

    // ------------------------------------------------------------------
    // Self-timed cycle and page buffer
    // ------------------------------------------------------------------
    // A supply drop stops the count; no copy-out follows
    dera_prog_timer #(
        .CYCLES (PROG_CYCLES),
        .CW     (16)
    ) u_timer (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .start   (ee_start),
        .abort   (!write_inhibit_flag_q),
        .busy_q  (busy),
        .done_q  (done)
    );

    // Slot is the low address bits only
    dera_page_buf #(
        .BYTES (PAGE_BYTES),
        .AW    (PAGE_AW)
    ) u_buf (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .wr       (ee_buf_wr),
        .wr_idx   (ee_addr[PAGE_AW-1:0]),
        .wr_data  (xd_wdata),
        .clr      (committing_q && commit_idx_q[PAGE_AW]),
        .rd_idx   (commit_idx_q[PAGE_AW-1:0]),
        .rd_data  (buf_rdata),
        .rd_valid (buf_rvalid)
    );

    // ------------------------------------------------------------------
    // Control register writes and supply status
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_only_q              <= 1'b0;
            eeprom_write_enable_q    <= 1'b0;
            internal_memory_enable_q <= 1'b0;
            pointer_select_q         <= 1'b0;
            write_inhibit_flag_q     <= 1'b1;
        end else begin
            // Supply flag follows the detector each cycle
            write_inhibit_flag_q <= supply_ok;
            // Ready and inhibit bits are read-only
            if (int_req && int_we && ctrl_hit) begin
                load_only_q              <= int_wdata[`DERA_BIT_LOAD];
                eeprom_write_enable_q    <= int_wdata[`DERA_BIT_WREN];
                internal_memory_enable_q <= int_wdata[`DERA_BIT_MEMEN];
                // 0 picks the first pointer bank, 1 the second
                pointer_select_q <= int_wdata[`DERA_BIT_PSEL];
            end
        end
    end

    // ------------------------------------------------------------------
    // Programming sequencer: latch target, commit at cycle end
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_addr_q  <= {EE_AW{1'b0}};
            prog_data_q  <= 8'h00;
            commit_idx_q <= {(PAGE_AW+1){1'b0}};
            committing_q <= 1'b0;
        end else begin
            // Only a starting write moves the target
            if (ee_start) begin
                prog_addr_q  <= ee_addr;
                prog_data_q  <= xd_wdata;
                commit_idx_q <= {(PAGE_AW+1){1'b0}};
            end

            // Copy-out begins the cycle after the timer ends
            if (done) begin
                committing_q <= 1'b1;
            end else if (committing_q) begin
                // One spare step clears the buffer
                if (commit_idx_q[PAGE_AW]) begin
                    committing_q <= 1'b0;
                end else begin
                    commit_idx_q <= commit_idx_q
                                    + {{PAGE_AW{1'b0}}, 1'b1};
                end
            end
        end
    end

    // Array update: only buffered slots of the one page change
    // Unloaded slots keep their old byte
    always @(posedge ref_clk) begin
        if (committing_q && !commit_idx_q[PAGE_AW] && buf_rvalid) begin
            eeprom[commit_addr] <= buf_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Internal RAM
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        // Direct writes above 7FH never land here
        if (int_req && int_we && !to_sfr) begin
            ram[int_addr] <= int_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Registered requests and read data
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_rdata_q  <= 8'h00;
            int_rd_sfr_q <= 1'b0;
            sfr_req_q    <= 1'b0;
            sfr_we_q     <= 1'b0;
            sfr_addr_q   <= 8'h00;
            sfr_wdata_q  <= 8'h00;
            xd_rdata_q   <= 8'h00;
            ext_req_q    <= 1'b0;
            ext_we_q     <= 1'b0;
            ext_addr_q   <= 16'h0000;
            ext_wdata_q  <= 8'h00;
        end else begin
            // Other special registers live outside this block
            sfr_req_q    <= int_req && to_sfr && !ctrl_hit;
            sfr_we_q     <= int_we;
            sfr_addr_q   <= int_addr;
            sfr_wdata_q  <= int_wdata;
            int_rd_sfr_q <= 1'b0;

            if (int_req && !int_we) begin
                if (ctrl_hit) begin
                    int_rdata_q <= ctrl_rd;
                end else if (to_sfr) begin
                    int_rd_sfr_q <= 1'b1;
                end else begin
                    int_rdata_q <= ram[int_addr];
                end
            end else if (int_rd_sfr_q) begin
                // A new read in this cycle would win instead
                int_rdata_q <= sfr_rdata;
            end

            // Off-chip reads return two cycles after the request
            ext_req_q   <= xd_req && !ee_hit;
            ext_we_q    <= xd_we;
            ext_addr_q  <= xd_addr;
            ext_wdata_q <= xd_wdata;

            if (xd_req && !xd_we && ee_hit) begin
                // Polling the byte under programming sees MSB flipped
                if (prog_busy && ee_addr == prog_addr_q) begin
                    xd_rdata_q <= {~prog_data_q[7],
                                   prog_data_q[6:0]};
                end else begin
                    xd_rdata_q <= eeprom[ee_addr];
                end
            end else if (ext_req_q && !ext_we_q) begin
                xd_rdata_q <= ext_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verilog/dera_defs.vh
/*
 * Constants for the data memory access block: control register offset,
 * field positions, reset value, memory geometry and write-cycle timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DERA_DEFS_VH
`define DERA_DEFS_VH

// ------------------------------------------------------------------
// Control register
// ------------------------------------------------------------------
`define DERA_CTRL_ADDR      8'h96
`define DERA_BIT_LOAD       5
`define DERA_BIT_WREN       4
`define DERA_BIT_MEMEN      3
`define DERA_BIT_PSEL       2
`define DERA_BIT_RDY        1
`define DERA_BIT_WINH       0
`define DERA_CTRL_RESET     8'h03

// ------------------------------------------------------------------
// Memory geometry
// ------------------------------------------------------------------
`define DERA_LOWER_TOP      8'h7F
`define DERA_EE_TOP         16'h07FF
`define DERA_EE_AW          11
`define DERA_PAGE_BYTES     32
`define DERA_PAGE_AW        5

// ------------------------------------------------------------------
// Timing: programming time in microseconds, clock in MHz
// ------------------------------------------------------------------
`define DERA_PROG_US        4000
`define DERA_CLK_MHZ        10
`define DERA_PROG_CYCLES    (`DERA_PROG_US * `DERA_CLK_MHZ)

`endif

// >>> verilog/dera_page_buf.v
/*
 * Volatile page write buffer: one byte and a loaded flag per page slot.
 * Assumes a single clock; clear empties all slots in one cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module dera_page_buf #(
    parameter BYTES = 32,
    parameter AW    = 5
) (
    input  wire          ref_clk,
    input  wire          arst_n,
    input  wire          wr,
    input  wire [AW-1:0] wr_idx,
    input  wire [7:0]    wr_data,
    input  wire          clr,
    input  wire [AW-1:0] rd_idx,
    output wire [7:0]    rd_data,
    output wire          rd_valid
);

    reg  [7:0]       mem [0:BYTES-1];
    reg  [BYTES-1:0] vld_q;

    assign rd_data  = mem[rd_idx];
    assign rd_valid = vld_q[rd_idx];

    // ------------------------------------------------------------------
    // Data array carries no reset; the valid flags guard it
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (wr) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Valid flags; a write in the clearing cycle still counts
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vld_q <= {BYTES{1'b0}};
        end else begin
            if (clr) begin
                vld_q <= {BYTES{1'b0}};
            end
            if (wr) begin
                vld_q[wr_idx] <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verilog/dera_prog_timer.v
/*
 * Self-timed programming cycle counter.
 * Assumes a single clock; start is a one-cycle pulse, abort a level.
 */
`timescale 1ns/10ps
`default_nettype none

module dera_prog_timer #(
    parameter CYCLES = 40000,
    parameter CW     = 16
) (
    input  wire          ref_clk,
    input  wire          arst_n,
    input  wire          start,
    input  wire          abort,
    output reg           busy_q,
    output reg           done_q
);

    reg  [CW-1:0]  cnt_q;

    // ------------------------------------------------------------------
    // Counter: runs while busy, abort stops without a done pulse
    // ------------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= {CW{1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
            end else if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            end else if (busy_q) begin
                if (cnt_q == {CW{1'b0}}) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire
